// ---- core/dtc_pkg.sv ----
`default_nettype none
package dtc_pkg;

	////////////////////////////////////////////////////////////////////////
	// mode register numbers as carried on a mode-register write or read
	localparam logic [5:0] MR_TERM_SETTING = 6'h0B;
	localparam logic [5:0] MR_TERM_RANK    = 6'h16;
	localparam logic [5:0] MR_SET_POINT    = 6'h0D;

	// termination setting fields
	localparam int DQ_CODE_LSB = 0;
	localparam int CA_CODE_LSB = 4;
	localparam int CODE_W      = 3;
	localparam logic [CODE_W-1:0] CODE_OFF = 3'h0;

	// termination rank fields
	localparam int RANK_CK_EN_BIT  = 3;
	localparam int RANK_CS_EN_BIT  = 4;
	localparam int RANK_CA_DIS_BIT = 5;

	// set point fields
	localparam int SP_WRITE_BIT   = 6;
	localparam int SP_OPERATE_BIT = 7;

	// reset values: both set points untermintated
	localparam logic [7:0] TERM_SETTING_RST = 8'h00;
	localparam logic [7:0] TERM_RANK_RST    = 8'h00;
	localparam logic [7:0] REG_READ_ZERO    = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// latency counts in command-clock cycles from the second CAS command
	localparam int LAT_W = 6;
	localparam logic [LAT_W-1:0] LAT_NONE    = 6'h00;
	localparam logic [LAT_W-1:0] BL32_EXTRA  = 6'h08;
	localparam logic [LAT_W-1:0] ON_B_800    = 6'h06;
	localparam logic [LAT_W-1:0] OFF_B_800   = 6'h16;
	localparam logic [LAT_W-1:0] ON_A_1066   = 6'h04;
	localparam logic [LAT_W-1:0] ON_B_1066   = 6'h0C;
	localparam logic [LAT_W-1:0] OFF_A_1066  = 6'h14;
	localparam logic [LAT_W-1:0] OFF_B_1066  = 6'h1C;
	localparam logic [LAT_W-1:0] ON_A_1333   = 6'h04;
	localparam logic [LAT_W-1:0] ON_B_1333   = 6'h0E;
	localparam logic [LAT_W-1:0] OFF_A_1333  = 6'h16;
	localparam logic [LAT_W-1:0] OFF_B_1333  = 6'h20;
	localparam logic [LAT_W-1:0] ON_A_1600   = 6'h06;
	localparam logic [LAT_W-1:0] ON_B_1600   = 6'h12;
	localparam logic [LAT_W-1:0] OFF_A_1600  = 6'h18;
	localparam logic [LAT_W-1:0] OFF_B_1600  = 6'h24;
	localparam logic [LAT_W-1:0] ON_A_1866   = 6'h06;
	localparam logic [LAT_W-1:0] ON_B_1866   = 6'h14;
	localparam logic [LAT_W-1:0] OFF_A_1866  = 6'h1A;
	localparam logic [LAT_W-1:0] OFF_B_1866  = 6'h28;
	localparam logic [LAT_W-1:0] ON_A_2133   = 6'h08;
	localparam logic [LAT_W-1:0] ON_B_2133   = 6'h18;
	localparam logic [LAT_W-1:0] OFF_A_2133  = 6'h1C;
	localparam logic [LAT_W-1:0] OFF_B_2133  = 6'h2C;
	localparam logic [LAT_W-1:0] CNT_START   = 6'h01;
	localparam logic [LAT_W-1:0] CNT_STEP    = 6'h01;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		DTC_BIN_266,
		DTC_BIN_533,
		DTC_BIN_800,
		DTC_BIN_1066,
		DTC_BIN_1333,
		DTC_BIN_1600,
		DTC_BIN_1866,
		DTC_BIN_2133
	} dtc_bin_e;

	typedef enum logic [1:0] {
		DTC_WR_WRITE,
		DTC_WR_MASK,
		DTC_WR_FIFO,
		DTC_WR_OTHER
	} dtc_cas_kind_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [5:0] addr;
		logic [7:0] data;
	} dtc_mrw_s;

	typedef struct packed {
		logic          cas2;
		dtc_cas_kind_e kind;
		logic          bl32;
		logic          wl_set_b;
	} dtc_cas_s;

	typedef struct packed {
		logic              ck_on;
		logic              cs_on;
		logic              ca_on;
		logic [CODE_W-1:0] code;
	} dtc_ca_term_s;

	typedef struct packed {
		logic              data_on;
		logic              strobe_on;
		logic [CODE_W-1:0] code;
	} dtc_dq_term_s;

	typedef struct packed {
		logic valid;
		logic [LAT_W-1:0] on_lat;
		logic [LAT_W-1:0] off_lat;
	} dtc_lat_s;

endpackage
`default_nettype wire

// ---- core/dtc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtc_core (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             ck,
	input  wire dtc_pkg::dtc_mrw_s mrw,
	input  wire dtc_pkg::dtc_cas_s cas,
	input  wire dtc_pkg::dtc_bin_e speed_bin,
	input  wire logic             cke,
	input  wire logic             power_down,
	input  wire logic             self_refresh,
	input  wire logic             write_leveling,
	output logic [7:0]            mrr_data_ff,
	output logic                  mrr_valid_ff,
	output dtc_pkg::dtc_ca_term_s ca_term_ff,
	output dtc_pkg::dtc_dq_term_s dq_term_ff,
	output logic                  core_ca_term_ff,
	output logic                  core_dq_term_ff
);

	////////////////////////////////////////////////////////////////////////
	// link-domain reset: asserted at once, released on the command clock
	logic ck_rst_meta_ff;
	logic ck_rst_n_ff;

	always_ff @(posedge ck or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ck_rst_meta_ff <= 1'b0;
			ck_rst_n_ff    <= 1'b0;
		end
		else
		begin
			ck_rst_meta_ff <= 1'b1;
			ck_rst_n_ff    <= ck_rst_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core power-state levels into the link domain
	logic [2:0] mode_meta_ff;
	logic [2:0] mode_sync_ff;

	always_ff @(posedge ck or negedge ck_rst_n_ff)
	begin
		if (!ck_rst_n_ff)
		begin
			mode_meta_ff <= 3'h0;
			mode_sync_ff <= 3'h0;
		end
		else
		begin
			mode_meta_ff <= {write_leveling, self_refresh, power_down};
			mode_sync_ff <= mode_meta_ff;
		end
	end

	logic pd_sync;
	logic sr_sync;
	logic wl_sync;
	assign pd_sync = mode_sync_ff[0];
	assign sr_sync = mode_sync_ff[1];
	assign wl_sync = mode_sync_ff[2];

	////////////////////////////////////////////////////////////////////////
	// setting and rank mode registers, one copy of each per set point
	logic [7:0] term_setting_ff [2];
	logic [7:0] term_rank_ff    [2];
	logic       sp_write_ff;
	logic       sp_operate_ff;

	always_ff @(posedge ck or negedge ck_rst_n_ff)
	begin
		if (!ck_rst_n_ff)
		begin
			term_setting_ff[0] <= dtc_pkg::TERM_SETTING_RST;
			term_setting_ff[1] <= dtc_pkg::TERM_SETTING_RST;
			term_rank_ff[0]    <= dtc_pkg::TERM_RANK_RST;
			term_rank_ff[1]    <= dtc_pkg::TERM_RANK_RST;
			sp_write_ff        <= 1'b0;
			sp_operate_ff      <= 1'b0;
		end
		else if (mrw.wr)
		begin
			unique case (mrw.addr)
				dtc_pkg::MR_TERM_SETTING:
					term_setting_ff[sp_write_ff] <= mrw.data;
				dtc_pkg::MR_TERM_RANK:
					term_rank_ff[sp_write_ff] <= mrw.data;
				dtc_pkg::MR_SET_POINT:
				begin
					sp_write_ff   <= mrw.data[dtc_pkg::SP_WRITE_BIT];
					sp_operate_ff <= mrw.data[dtc_pkg::SP_OPERATE_BIT];
				end
				default:
				begin
				end
			endcase
		end
	end

	// mode-register read returns the copy chosen for writing
	logic [7:0] nxt_mrr_data;

	always_comb
	begin
		nxt_mrr_data = dtc_pkg::REG_READ_ZERO;
		if (mrw.addr == dtc_pkg::MR_TERM_SETTING)
			nxt_mrr_data = term_setting_ff[sp_write_ff];
		else if (mrw.addr == dtc_pkg::MR_TERM_RANK)
			nxt_mrr_data = term_rank_ff[sp_write_ff];
	end

	always_ff @(posedge ck or negedge ck_rst_n_ff)
	begin
		if (!ck_rst_n_ff)
		begin
			mrr_data_ff  <= dtc_pkg::REG_READ_ZERO;
			mrr_valid_ff <= 1'b0;
		end
		else
		begin
			mrr_valid_ff <= mrw.rd;
			if (mrw.rd)
				mrr_data_ff <= nxt_mrr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operating copy of the fields
	logic [7:0]                  op_setting;
	logic [7:0]                  op_rank;
	logic [dtc_pkg::CODE_W-1:0]  ca_code;
	logic [dtc_pkg::CODE_W-1:0]  dq_code;
	assign op_setting = term_setting_ff[sp_operate_ff];
	assign op_rank    = term_rank_ff[sp_operate_ff];
	assign ca_code    = op_setting[dtc_pkg::CA_CODE_LSB +: dtc_pkg::CODE_W];
	assign dq_code    = op_setting[dtc_pkg::DQ_CODE_LSB +: dtc_pkg::CODE_W];

	////////////////////////////////////////////////////////////////////////
	// command bus termination
	dtc_pkg::dtc_ca_term_s nxt_ca_term;
	logic                  term_rank;

	always_comb
	begin
		term_rank = !op_rank[dtc_pkg::RANK_CA_DIS_BIT]
			&& !op_rank[dtc_pkg::RANK_CK_EN_BIT]
			&& !op_rank[dtc_pkg::RANK_CS_EN_BIT];
		nxt_ca_term.code  = ca_code;
		nxt_ca_term.ca_on = 1'b0;
		nxt_ca_term.ck_on = 1'b0;
		nxt_ca_term.cs_on = 1'b0;
		if (ca_code != dtc_pkg::CODE_OFF)
		begin
			nxt_ca_term.ca_on = !op_rank[dtc_pkg::RANK_CA_DIS_BIT];
			nxt_ca_term.ck_on = term_rank
				|| op_rank[dtc_pkg::RANK_CK_EN_BIT];
			nxt_ca_term.cs_on = term_rank
				|| op_rank[dtc_pkg::RANK_CS_EN_BIT];
		end
	end

	always_ff @(posedge ck or negedge ck_rst_n_ff)
	begin
		if (!ck_rst_n_ff)
			ca_term_ff <= '0;
		else
			ca_term_ff <= nxt_ca_term;
	end

	////////////////////////////////////////////////////////////////////////
	// data termination latency per speed bin and write latency set
	function automatic dtc_pkg::dtc_lat_s lat_lookup(
		input dtc_pkg::dtc_bin_e bin,
		input logic              set_b,
		input logic              bl32
	);
		dtc_pkg::dtc_lat_s l;
		l.valid   = 1'b1;
		l.on_lat  = dtc_pkg::LAT_NONE;
		l.off_lat = dtc_pkg::LAT_NONE;
		unique case (bin)
			dtc_pkg::DTC_BIN_266,
			dtc_pkg::DTC_BIN_533:
				l.valid = 1'b0;
			dtc_pkg::DTC_BIN_800:
			begin
				l.valid   = set_b;
				l.on_lat  = dtc_pkg::ON_B_800;
				l.off_lat = dtc_pkg::OFF_B_800;
			end
			dtc_pkg::DTC_BIN_1066:
			begin
				l.on_lat  = set_b ? dtc_pkg::ON_B_1066 : dtc_pkg::ON_A_1066;
				l.off_lat = set_b ? dtc_pkg::OFF_B_1066 : dtc_pkg::OFF_A_1066;
			end
			dtc_pkg::DTC_BIN_1333:
			begin
				l.on_lat  = set_b ? dtc_pkg::ON_B_1333 : dtc_pkg::ON_A_1333;
				l.off_lat = set_b ? dtc_pkg::OFF_B_1333 : dtc_pkg::OFF_A_1333;
			end
			dtc_pkg::DTC_BIN_1600:
			begin
				l.on_lat  = set_b ? dtc_pkg::ON_B_1600 : dtc_pkg::ON_A_1600;
				l.off_lat = set_b ? dtc_pkg::OFF_B_1600 : dtc_pkg::OFF_A_1600;
			end
			dtc_pkg::DTC_BIN_1866:
			begin
				l.on_lat  = set_b ? dtc_pkg::ON_B_1866 : dtc_pkg::ON_A_1866;
				l.off_lat = set_b ? dtc_pkg::OFF_B_1866 : dtc_pkg::OFF_A_1866;
			end
			dtc_pkg::DTC_BIN_2133:
			begin
				l.on_lat  = set_b ? dtc_pkg::ON_B_2133 : dtc_pkg::ON_A_2133;
				l.off_lat = set_b ? dtc_pkg::OFF_B_2133 : dtc_pkg::OFF_A_2133;
			end
		endcase
		if (bl32)
			l.off_lat = l.off_lat + dtc_pkg::BL32_EXTRA;
		return l;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// write burst window, counted in command-clock cycles from CAS-2
	typedef enum logic [1:0] {
		DTC_DQ_IDLE,
		DTC_DQ_WAIT_ON,
		DTC_DQ_ON
	} dtc_dq_state_e;

	dtc_dq_state_e           dq_state_ff;
	logic [dtc_pkg::LAT_W-1:0] cnt_ff;
	logic [dtc_pkg::LAT_W-1:0] on_at_ff;
	logic [dtc_pkg::LAT_W-1:0] off_at_ff;
	dtc_pkg::dtc_lat_s       lat;
	logic                    wr_cmd;

	assign lat    = lat_lookup(speed_bin, cas.wl_set_b, cas.bl32);
	assign wr_cmd = cas.cas2 && (cas.kind != dtc_pkg::DTC_WR_OTHER)
		&& (dq_code != dtc_pkg::CODE_OFF) && lat.valid;

	always_ff @(posedge ck or negedge ck_rst_n_ff)
	begin
		if (!ck_rst_n_ff)
		begin
			dq_state_ff <= DTC_DQ_IDLE;
			cnt_ff      <= dtc_pkg::LAT_NONE;
			on_at_ff    <= dtc_pkg::LAT_NONE;
			off_at_ff   <= dtc_pkg::LAT_NONE;
		end
		else if (wr_cmd)
		begin
			// a new write restarts the window; an open window stays open
			cnt_ff    <= dtc_pkg::CNT_START;
			on_at_ff  <= lat.on_lat;
			off_at_ff <= lat.off_lat;
			if (dq_state_ff == DTC_DQ_IDLE)
				dq_state_ff <= DTC_DQ_WAIT_ON;
		end
		else
		begin
			cnt_ff <= cnt_ff + dtc_pkg::CNT_STEP;
			unique case (dq_state_ff)
				DTC_DQ_IDLE:
					cnt_ff <= dtc_pkg::LAT_NONE;
				DTC_DQ_WAIT_ON:
					if (cnt_ff == on_at_ff)
						dq_state_ff <= DTC_DQ_ON;
				DTC_DQ_ON:
					if (cnt_ff == off_at_ff)
						dq_state_ff <= DTC_DQ_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data termination outputs with power-state gating
	dtc_pkg::dtc_dq_term_s nxt_dq_term;
	logic                  burst_on;
	logic                  dq_allowed;

	always_comb
	begin
		burst_on = (dq_state_ff == DTC_DQ_WAIT_ON && cnt_ff == on_at_ff)
			|| (dq_state_ff == DTC_DQ_ON && cnt_ff != off_at_ff);
		dq_allowed = (dq_code != dtc_pkg::CODE_OFF)
			&& !pd_sync
			&& !(sr_sync && !cke);
		nxt_dq_term.code      = dq_code;
		nxt_dq_term.data_on   = 1'b0;
		nxt_dq_term.strobe_on = 1'b0;
		if (wl_sync)
			nxt_dq_term.strobe_on = dq_allowed;
		else if (dq_allowed && burst_on)
		begin
			nxt_dq_term.data_on   = 1'b1;
			nxt_dq_term.strobe_on = 1'b1;
		end
	end

	always_ff @(posedge ck or negedge ck_rst_n_ff)
	begin
		if (!ck_rst_n_ff)
			dq_term_ff <= '0;
		else
			dq_term_ff <= nxt_dq_term;
	end

	////////////////////////////////////////////////////////////////////////
	// termination activity reported into the core domain
	logic [1:0] stat_meta_ff;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stat_meta_ff    <= 2'h0;
			core_ca_term_ff <= 1'b0;
			core_dq_term_ff <= 1'b0;
		end
		else
		begin
			stat_meta_ff    <= {dq_term_ff.data_on | dq_term_ff.strobe_on,
				ca_term_ff.ca_on | ca_term_ff.ck_on | ca_term_ff.cs_on};
			core_ca_term_ff <= stat_meta_ff[0];
			core_dq_term_ff <= stat_meta_ff[1];
		end
	end

endmodule // dtc_core
`default_nettype wire

// ---- tb/dtc_core_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtc_core_sva (
	input wire logic                  clk,
	input wire logic                  reset_n,
	input wire logic                  ck,
	input wire dtc_pkg::dtc_mrw_s     mrw,
	input wire dtc_pkg::dtc_cas_s     cas,
	input wire dtc_pkg::dtc_bin_e     speed_bin,
	input wire logic                  cke,
	input wire logic                  power_down,
	input wire logic                  self_refresh,
	input wire logic                  write_leveling,
	input wire logic                  mrr_valid_ff,
	input wire dtc_pkg::dtc_ca_term_s ca_term_ff,
	input wire dtc_pkg::dtc_dq_term_s dq_term_ff,
	input wire logic                  core_ca_term_ff,
	input wire logic                  core_dq_term_ff
);
	logic [1:0] sp_ff;
	logic       any_ca;
	logic       any_dq;
	logic       go;

	// set-point selects, so a write can be tied to the outputs
	always_ff @(posedge ck or negedge reset_n)
	begin
		if (!reset_n)
			sp_ff <= 2'h0;
		else if (mrw.wr && mrw.addr == dtc_pkg::MR_SET_POINT)
			sp_ff <= mrw.data[7:6];
	end
	assign any_ca = |ca_term_ff[5:3];
	assign any_dq = dq_term_ff.data_on | dq_term_ff.strobe_on;
	assign go = cas.cas2 && cas.kind != dtc_pkg::DTC_WR_OTHER
		&& dq_term_ff.code != 3'h0 && !power_down && !self_refresh
		&& !write_leveling;

	//////////////////////////////////////////////////////////////////
	ca_off_a: assert property (@(posedge ck) disable iff (!reset_n)
		ca_term_ff.code == 3'h0 |-> !any_ca)
		else $error("ca termination on with code off");
	dq_code_a: assert property (@(posedge ck) disable iff (!reset_n)
		dq_term_ff.data_on |-> dq_term_ff.code != 3'h0)
		else $error("data termination on with code off");
	mr_set_a: assert property (@(posedge ck) disable iff (!reset_n)
		mrw.wr && mrw.addr == dtc_pkg::MR_TERM_SETTING
		&& sp_ff[0] == sp_ff[1] |-> ##2
		ca_term_ff.code == $past(mrw.data[6:4], 2)
		&& dq_term_ff.code == $past(mrw.data[2:0], 2))
		else $error("setting write not applied");
	burst_short_a: assert property (@(posedge ck) disable iff (!reset_n)
		go && speed_bin == dtc_pkg::DTC_BIN_1066 && !cas.wl_set_b
		&& !cas.bl32 |-> ##4 !dq_term_ff.data_on ##1 dq_term_ff.data_on[*8]
		##1 dq_term_ff.data_on[*8] ##1 !dq_term_ff.data_on)
		else $error("termination window wrong, short burst");
	burst_long_a: assert property (@(posedge ck) disable iff (!reset_n)
		go && speed_bin == dtc_pkg::DTC_BIN_2133 && cas.wl_set_b
		&& cas.bl32 |-> ##24 !dq_term_ff.data_on ##1 dq_term_ff.data_on[*8]
		##20 dq_term_ff.data_on ##1 !dq_term_ff.data_on)
		else $error("termination window wrong, long burst");
	pd_off_a: assert property (@(posedge ck) disable iff (!reset_n)
		power_down[*5] |-> !any_dq)
		else $error("data termination on in power-down");
	sr_off_a: assert property (@(posedge ck) disable iff (!reset_n)
		(self_refresh && !cke)[*5] |-> !any_dq)
		else $error("data termination on in self refresh");
	wl_term_a: assert property (@(posedge ck) disable iff (!reset_n)
		(write_leveling && !power_down && !(self_refresh && !cke))[*5]
		|-> !dq_term_ff.data_on
		&& dq_term_ff.strobe_on == (dq_term_ff.code != 3'h0))
		else $error("write leveling termination wrong");
	mrr_pulse_a: assert property (@(posedge ck) disable iff (!reset_n)
		mrr_valid_ff == $past(mrw.rd))
		else $error("read valid not one cycle after read");
	core_ca_a: assert property (@(posedge clk) disable iff (!reset_n)
		any_ca[*4] |-> core_ca_term_ff)
		else $error("core copy of ca termination missing");
	core_dq_a: assert property (@(posedge clk) disable iff (!reset_n)
		!any_dq[*4] |-> !core_dq_term_ff)
		else $error("core copy of dq termination stuck");
	c_burst: cover property (@(posedge ck) go);
	c_wl: cover property (@(posedge ck) write_leveling && any_dq);
	c_mrr: cover property (@(posedge ck) mrr_valid_ff);
endmodule // dtc_core_sva
bind dtc_core dtc_core_sva u_sva (.clk(clk), .reset_n(reset_n), .ck(ck),
	.mrw(mrw), .cas(cas), .speed_bin(speed_bin), .cke(cke),
	.power_down(power_down), .self_refresh(self_refresh),
	.write_leveling(write_leveling), .mrr_valid_ff(mrr_valid_ff),
	.ca_term_ff(ca_term_ff), .dq_term_ff(dq_term_ff),
	.core_ca_term_ff(core_ca_term_ff), .core_dq_term_ff(core_dq_term_ff));
`default_nettype wire

// ---- tb/dtc_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// no data drive here, so nothing overlaps termination windows
// pull-up calibration point never changes: values change freely
module dtc_ctl_model (
	output logic              ck,
	output dtc_pkg::dtc_mrw_s mrw,
	output dtc_pkg::dtc_cas_s cas,
	output dtc_pkg::dtc_bin_e speed_bin,
	output logic              cke
);
	initial
	begin
		ck = 1'h0;
		mrw = 16'h0000;
		cas = 5'h00;
		speed_bin = dtc_pkg::DTC_BIN_1066;
		cke = 1'h1;
		#3;
		forever #6 ck = ~ck;
	end

	task automatic mr_op(input logic rd, input logic [5:0] a,
		input logic [7:0] d);
		@(negedge ck);
		mrw = {~rd, rd, a, d};
		@(negedge ck);
		// released fields no longer show the last value
		mrw = {2'h0, ~a, ~d};
	endtask

	task automatic cas_op(input logic [1:0] k, input logic [2:0] b,
		input logic sb, input logic l32);
		speed_bin = dtc_pkg::dtc_bin_e'(b);
		repeat (3) @(negedge ck);
		cas = {1'h1, k, l32, sb};
		@(negedge ck);
		cas = {1'h0, ~k, ~l32, ~sb};
	endtask

	task automatic set_cke(input logic v);
		@(negedge ck);
		cke = v;
	endtask
endmodule // dtc_ctl_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [7:0] rank;
		logic [7:0] set;
		logic [5:0] ca;
	} dtc_row_s;
	typedef struct packed {
		logic [1:0] k;
		logic [2:0] b;
		logic       sb;
		logic       l32;
		logic [7:0] on;
		logic [7:0] off;
	} dtc_lrow_s;
	logic                  clk;
	logic                  reset_n;
	logic                  power_down;
	logic                  self_refresh;
	logic                  write_leveling;
	logic                  ck;
	logic                  cke;
	logic [7:0]            mrr_data_ff;
	logic                  mrr_valid_ff;
	logic                  core_ca_term_ff;
	logic                  core_dq_term_ff;
	dtc_pkg::dtc_mrw_s     mrw;
	dtc_pkg::dtc_cas_s     cas;
	dtc_pkg::dtc_bin_e     speed_bin;
	dtc_pkg::dtc_ca_term_s ca_term_ff;
	dtc_pkg::dtc_dq_term_s dq_term_ff;
	int                    miscompares;
	int                    n_tests;
	int                    t_on;
	int                    t_off;
	// rank bits, setting, expected {ck_on, cs_on, ca_on, code}
	// terminating rank first, then the non-terminating ones, then two rows with the CA code off
	dtc_row_s rows [10] = '{'{8'h00, 8'h11, 6'h39}, '{8'h08, 8'h22, 6'h2A},
		'{8'h10, 8'h33, 6'h1B}, '{8'h18, 8'h44, 6'h3C},
		'{8'h20, 8'h55, 6'h05}, '{8'h28, 8'h66, 6'h26},
		'{8'h30, 8'h11, 6'h11}, '{8'h38, 8'h22, 6'h32},
		'{8'h00, 8'h01, 6'h00}, '{8'h38, 8'h06, 6'h00}};
	// kind, bin, set b, long burst, on and off edge (0 = never)
	dtc_lrow_s lats [8] = '{'{2'h0, 3'h3, 1'h0, 1'h0, 8'h04, 8'h14},
		'{2'h1, 3'h3, 1'h1, 1'h0, 8'h0C, 8'h1C},
		'{2'h2, 3'h7, 1'h0, 1'h0, 8'h08, 8'h1C},
		'{2'h0, 3'h7, 1'h1, 1'h1, 8'h18, 8'h34},
		'{2'h0, 3'h2, 1'h1, 1'h0, 8'h06, 8'h16},
		'{2'h0, 3'h2, 1'h0, 1'h0, 8'h00, 8'h00},
		'{2'h0, 3'h1, 1'h1, 1'h0, 8'h00, 8'h00},
		'{2'h3, 3'h3, 1'h0, 1'h0, 8'h00, 8'h00}};

	dtc_ctl_model ctl (.ck(ck), .mrw(mrw), .cas(cas),
		.speed_bin(speed_bin), .cke(cke));
	dtc_core uut (.clk(clk), .reset_n(reset_n), .ck(ck), .mrw(mrw),
		.cas(cas), .speed_bin(speed_bin), .cke(cke),
		.power_down(power_down), .self_refresh(self_refresh),
		.write_leveling(write_leveling), .mrr_data_ff(mrr_data_ff),
		.mrr_valid_ff(mrr_valid_ff), .ca_term_ff(ca_term_ff),
		.dq_term_ff(dq_term_ff), .core_ca_term_ff(core_ca_term_ff),
		.core_dq_term_ff(core_dq_term_ff));

	always #4 clk = ~clk;

	task automatic chk(input string nm, input logic [7:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic final_report;
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// edges after the command until data termination shows on and off
	task automatic burst(input logic [1:0] k, input logic [2:0] b,
		input logic sb, input logic l32);
		t_on = 0;
		t_off = 0;
		ctl.cas_op(k, b, sb, l32);
		for (int i = 1; i < 70; i++)
		begin
			@(posedge ck);
			#1;
			if (dq_term_ff.data_on === 1'h1 && t_on == 0)
				t_on = i;
			if (dq_term_ff.data_on === 1'h0 && t_on != 0 && t_off == 0)
				t_off = i;
		end
	endtask

	task automatic mode(input logic [2:0] m);
		@(negedge clk);
		{power_down, self_refresh, write_leveling} = m;
		repeat (8) @(posedge ck);
		#1;
	endtask

	task automatic settle;
		@(posedge ck);
		#1;
	endtask

	initial
	begin
		#60000;
		miscompares++;
		final_report;
	end

	initial
	begin
		clk = 1'h0;
		reset_n = 1'h0;
		{power_down, self_refresh, write_leveling} = 3'h0;
		miscompares = 0;
		n_tests = 0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset_n = 1'h1;
		repeat (6) @(posedge ck);
		chk("ca_rst", 8'h00, {2'h0, ca_term_ff});
		chk("dq_rst", 8'h00, {3'h0, dq_term_ff});
		foreach (rows[i])
		begin
			ctl.mr_op(1'h0, dtc_pkg::MR_TERM_RANK, rows[i].rank);
			ctl.mr_op(1'h0, dtc_pkg::MR_TERM_SETTING, rows[i].set);
			ctl.mr_op(1'h1, dtc_pkg::MR_TERM_SETTING, 8'h00);
			settle();
			chk("ca_term", {2'h0, rows[i].ca}, {2'h0, ca_term_ff});
			chk("dq_code", rows[i].set & 8'h07, {5'h00, dq_term_ff.code});
			chk("mrr", rows[i].set, mrr_data_ff);
			chk("core_ca", {7'h00, rows[i].ca[5:3] != 3'h0},
				{7'h00, core_ca_term_ff});
		end
		foreach (lats[i])
		begin
			burst(lats[i].k, lats[i].b, lats[i].sb, lats[i].l32);
			chk("on_lat", lats[i].on, 8'(t_on));
			chk("off_lat", lats[i].off, 8'(t_off));
		end
		ctl.mr_op(1'h0, dtc_pkg::MR_SET_POINT, 8'h40);
		ctl.mr_op(1'h0, dtc_pkg::MR_TERM_RANK, 8'h38);
		ctl.mr_op(1'h0, dtc_pkg::MR_TERM_SETTING, 8'h33);
		ctl.mr_op(1'h1, dtc_pkg::MR_TERM_SETTING, 8'h00);
		settle();
		chk("fsp_keep", 8'h00, {2'h0, ca_term_ff});
		chk("fsp_read", 8'h33, mrr_data_ff);
		ctl.mr_op(1'h0, dtc_pkg::MR_SET_POINT, 8'hC0);
		settle();
		chk("set_point_operate_select", 8'h33, {2'h0, ca_term_ff});
		ctl.mr_op(1'h0, dtc_pkg::MR_SET_POINT, 8'h00);
		ctl.mr_op(1'h1, 6'h05, 8'h00);
		settle();
		chk("unmapped", 8'h00, mrr_data_ff);
		mode(3'h4);
		burst(2'h0, 3'h3, 1'h0, 1'h0);
		chk("pd_on", 8'h00, 8'(t_on));
		mode(3'h2);
		ctl.set_cke(1'h0);
		burst(2'h0, 3'h3, 1'h0, 1'h0);
		chk("sr_low", 8'h00, 8'(t_on));
		ctl.set_cke(1'h1);
		burst(2'h0, 3'h3, 1'h0, 1'h0);
		chk("sr_high", 8'h04, 8'(t_on));
		mode(3'h1);
		chk("wl_on", 8'h0E, {3'h0, dq_term_ff});
		chk("core_dq", 8'h01, {7'h00, core_dq_term_ff});
		ctl.mr_op(1'h0, dtc_pkg::MR_TERM_SETTING, 8'h00);
		settle();
		chk("wl_off", 8'h00, {3'h0, dq_term_ff});
		mode(3'h0);
		chk("core_idle", 8'h00, {7'h00, core_dq_term_ff});
		final_report;
	end
endmodule // tb_top
`default_nettype wire
